// ---- hw/rab_pkg.sv ----
// package: register map, field positions and timing for rt address/busy select
package rab_pkg;
    // ------------------------------------------------------------------
    // register byte offsets (wishbone, one word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CFG2 = 8'h00;
    localparam logic [7:0] OFF_CFG3 = 8'h04;
    localparam logic [7:0] OFF_CFG4 = 8'h08;
    localparam logic [7:0] OFF_CFG5 = 8'h0C;
    localparam logic [7:0] OFF_BUSY_BASE = 8'h20;
    localparam int BUSY_WORDS = 8;
    localparam int BUSY_IDX_W = 3;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CFG2_LOOKUP_EN_BIT = 13;
    localparam int CFG3_ENH_BIT = 15;
    localparam int CFG4_SW_CAPTURE_BIT = 3;
    localparam int CFG5_BCAST_OFF_BIT = 7;
    localparam int CFG5_LATCH_SEL_BIT = 6;
    localparam int CFG5_ADDR_LSB = 1;
    localparam int CFG5_PAR_BIT = 0;
    localparam int IDX_BCAST_BIT = 2;
    localparam int IDX_TR_BIT = 1;
    localparam int IDX_SA_MSB_BIT = 0;
    localparam logic [4:0] BCAST_ADDR = 5'h1F;
    localparam logic [15:0] BUSY_TABLE_BASE = 16'h0240;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int SAMPLE_DELAY_NS = 2000;
    localparam int SAMPLE_DELAY_CYC = (SAMPLE_DELAY_NS * CLK_MHZ) / 1000;
    localparam int SAMPLE_CNT_W = 7;
    typedef enum logic [1:0] {MS_IDLE, MS_WAIT, MS_DONE} rab_match_t;
endpackage : rab_pkg

// ---- hw/rab_cmd_if.sv ----
// interface: command word handed from the matcher to the busy lookup
`timescale 1ns/1ps
interface rab_cmd_if;
    logic valid;
    logic bcast;
    logic tr;
    logic [4:0] subaddr;
    logic enable;
    logic busy;
    modport ctrl (output valid, output bcast, output tr, output subaddr,
                  output enable, input busy);
    modport lookup (input valid, input bcast, input tr, input subaddr,
                    input enable, output busy);
endinterface : rab_cmd_if

// ---- hw/rab_busy_lookup.sv ----
// module: per-subaddress busy bit selection from the lookup words
`timescale 1ns/1ps
module rab_busy_lookup
    import rab_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // table contents
    input wire logic [16*BUSY_WORDS-1:0] i_table,
    // command side
    rab_cmd_if.lookup cmd
);
    // ------------------------------------------------------------------
    // index and bit select
    // ------------------------------------------------------------------
    logic [BUSY_IDX_W-1:0] idx;
    logic [15:0] word_sel;
    logic hit;
    assign idx = {cmd.bcast, cmd.tr, cmd.subaddr[4]}; // RL16
    assign word_sel = i_table[16*idx +: 16]; // RL14 RL15
    assign hit = word_sel[cmd.subaddr[3:0]];

    logic busy_reg;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            busy_reg <= 1'b0;
        end else if (cmd.valid) begin
            busy_reg <= cmd.enable & hit; // RL17 RL18
        end
    end
    assign cmd.busy = busy_reg;

    busy_follows_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        cmd.valid |=> busy_reg == ($past(cmd.enable) && $past(hit))) // RL18
        else $error("busy bit does not follow selected table bit");
    busy_gated_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        cmd.valid && !cmd.enable |=> !busy_reg) // RL17
        else $error("busy set while lookup disabled");
endmodule : rab_busy_lookup

// ---- hw/rab_addr_select.sv ----
// module: rt address hold, command match, broadcast and busy select
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
// Function
// (RL1) respond when address matches, parity odd
// (RL2) accept address 31 unless broadcast off
// (RL3) sample address 2 us after mid-parity
// (RL4) strap parity makes odd ones count
// (RL5) latch-select low hardwired, high latched
// (RL6) cfg5 reads latch-select and held address; the code returns both only while enhanced mode is set
// (RL7) hardwired mode tracks inputs continuously
// (RL8) latch-select rising edge loads latch
// (RL9) cfg5 write loads latch when enabled
// (RL10) host avoids capture in zero-wait mode
// (RL11) master clear zeroes latch and parity
// (RL12) soft and mode reset keep latch
// (RL13) board wires straps onto data bits
// (RL14) low word bit n marks subaddress n
// (RL15) high word bit n marks n plus 16
// (RL16) index from broadcast, t/r, subaddress msb
// (RL17) lookup only enhanced with enable set
// (RL18) selected bit one sets busy status
// (RL19) compare against inputs or latch by mode
module rab_addr_select
    import rab_pkg::*;
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESETN,
    // wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    // straps
    input wire logic [4:0] I_TERM_ADDR_IN,
    input wire logic I_TERM_ADDR_PARITY_IN,
    input wire logic I_ADDR_LATCH_SELECT,
    input wire logic I_MASTER_CLEAR_N,
    // decoded command
    input wire logic I_CMD_STROBE,
    input wire logic [4:0] I_CMD_ADDR,
    input wire logic I_CMD_TR,
    input wire logic [4:0] I_CMD_SUBADDR,
    // result
    output logic O_MATCH_VALID,
    output logic O_OWN_MATCH,
    output logic O_BCAST_MATCH,
    output logic O_BUSY,
    output logic [5:0] O_HELD_ADDR
);
    // ------------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------------
    logic [15:0] cfg2_reg;
    logic [15:0] cfg3_reg;
    logic [15:0] cfg4_reg;
    logic cfg5_bcast_off_reg;
    logic [15:0] busy_reg [BUSY_WORDS];
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic req;
    logic wr;
    logic busy_hit;
    logic [BUSY_IDX_W-1:0] busy_wr_idx;
    assign req = I_WB_CYC & I_WB_STB & ~ack_reg;
    assign wr = req & I_WB_WE;
    assign busy_hit = (I_WB_ADR >= OFF_BUSY_BASE) &&
        (I_WB_ADR < OFF_BUSY_BASE + 8'(4 * BUSY_WORDS)) &&
        (I_WB_ADR[1:0] == 2'h0);
    assign busy_wr_idx = BUSY_IDX_W'((I_WB_ADR - OFF_BUSY_BASE) >> 2);

    logic enh;
    logic sw_capture_en;
    logic lookup_en;
    assign enh = cfg3_reg[CFG3_ENH_BIT];
    assign sw_capture_en = cfg4_reg[CFG4_SW_CAPTURE_BIT];
    assign lookup_en = enh & cfg2_reg[CFG2_LOOKUP_EN_BIT];

    // soft reset elsewhere never reaches these; only the bus reset does
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            cfg2_reg <= 16'h0000;
            cfg3_reg <= 16'h0000;
            cfg4_reg <= 16'h0000;
            cfg5_bcast_off_reg <= 1'b0;
        end else if (wr) begin
            if (I_WB_ADR == OFF_CFG2 && I_WB_SEL[1:0] == 2'h3) begin
                cfg2_reg <= I_WB_DAT[15:0];
            end
            if (I_WB_ADR == OFF_CFG3 && I_WB_SEL[1:0] == 2'h3) begin
                cfg3_reg <= I_WB_DAT[15:0];
            end
            if (I_WB_ADR == OFF_CFG4 && I_WB_SEL[1:0] == 2'h3) begin
                cfg4_reg <= I_WB_DAT[15:0];
            end
            if (I_WB_ADR == OFF_CFG5 && I_WB_SEL[0]) begin
                cfg5_bcast_off_reg <= I_WB_DAT[CFG5_BCAST_OFF_BIT];
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < BUSY_WORDS; gi++) begin : g_busy
            always_ff @(posedge I_CLK or negedge I_RESETN) begin
                if (!I_RESETN) begin
                    busy_reg[gi] <= 16'h0000;
                end else if (wr && busy_hit && busy_wr_idx == gi
                             && I_WB_SEL[1:0] == 2'h3) begin
                    busy_reg[gi] <= I_WB_DAT[15:0];
                end
            end
        end
    endgenerate

    logic [16*BUSY_WORDS-1:0] table_flat;
    always_comb begin
        table_flat = '0;
        for (int k = 0; k < BUSY_WORDS; k++) begin
            table_flat[16*k +: 16] = busy_reg[k];
        end
    end

    // ------------------------------------------------------------------
    // address latch
    // ------------------------------------------------------------------
    logic [5:0] latch_reg;
    logic sel_prev_reg;
    logic latch_mode;
    logic sel_rise;
    logic cfg5_write;
    logic [5:0] strap;
    assign latch_mode = I_ADDR_LATCH_SELECT; // RL5
    assign strap = {I_TERM_ADDR_IN, I_TERM_ADDR_PARITY_IN};
    assign sel_rise = I_ADDR_LATCH_SELECT & ~sel_prev_reg;
    assign cfg5_write = wr && I_WB_ADR == OFF_CFG5;

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            sel_prev_reg <= 1'b1;
        end else begin
            sel_prev_reg <= I_ADDR_LATCH_SELECT;
        end
    end

    // master clear is its own reset: bus-side soft resets leave it alone
    always_ff @(posedge I_CLK or negedge I_MASTER_CLEAR_N) begin
        if (!I_MASTER_CLEAR_N) begin
            latch_reg <= 6'h00; // RL11 RL12
        end else if (sel_rise) begin
            latch_reg <= strap; // RL8
        end else if (cfg5_write && enh && sw_capture_en) begin
            latch_reg <= strap; // RL9
        end
    end

    logic [5:0] held;
    assign held = latch_mode ? latch_reg : strap; // RL7 RL19
    assign O_HELD_ADDR = held;

    // read data registered; reads of unmapped offsets return zero
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req;
            rdat_reg <= 32'h0000_0000;
            if (req && !I_WB_WE) begin
                if (I_WB_ADR == OFF_CFG2) begin
                    rdat_reg[15:0] <= cfg2_reg;
                end else if (I_WB_ADR == OFF_CFG3) begin
                    rdat_reg[15:0] <= cfg3_reg;
                end else if (I_WB_ADR == OFF_CFG4) begin
                    rdat_reg[15:0] <= cfg4_reg;
                end else if (I_WB_ADR == OFF_CFG5) begin
                    rdat_reg[CFG5_BCAST_OFF_BIT] <= cfg5_bcast_off_reg;
                    if (enh) begin
                        rdat_reg[CFG5_LATCH_SEL_BIT] <= latch_mode; // RL6
                        rdat_reg[5:0] <= held; // RL6
                    end
                end else if (busy_hit) begin
                    rdat_reg[15:0] <= busy_reg[busy_wr_idx];
                end
            end
        end
    end
    assign O_WB_ACK = ack_reg;
    assign O_WB_DAT = rdat_reg;

    // ------------------------------------------------------------------
    // command match
    // ------------------------------------------------------------------
    rab_match_t state_reg;
    logic [SAMPLE_CNT_W-1:0] cnt_reg;
    logic [4:0] cmd_addr_reg;
    logic cmd_tr_reg;
    logic [4:0] cmd_sa_reg;
    logic own_reg;
    logic bc_reg;
    logic own_next;
    logic bc_next;
    logic sample;
    assign sample = state_reg == MS_WAIT &&
        cnt_reg == SAMPLE_CNT_W'(SAMPLE_DELAY_CYC - 1);
    assign own_next = (held[5:1] == cmd_addr_reg) && (^held) &&
        !(cmd_addr_reg == BCAST_ADDR && !cfg5_bcast_off_reg); // RL1
    assign bc_next = cmd_addr_reg == BCAST_ADDR && !cfg5_bcast_off_reg; // RL2

    // a new command restarts the wait, superseding the one in flight
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_reg <= MS_IDLE;
            cnt_reg <= '0;
            cmd_addr_reg <= 5'h00;
            cmd_tr_reg <= 1'b0;
            cmd_sa_reg <= 5'h00;
        end else if (I_CMD_STROBE) begin
            state_reg <= MS_WAIT;
            cnt_reg <= '0;
            cmd_addr_reg <= I_CMD_ADDR;
            cmd_tr_reg <= I_CMD_TR;
            cmd_sa_reg <= I_CMD_SUBADDR;
        end else begin
            case (state_reg)
                MS_IDLE: begin
                    cnt_reg <= '0;
                end
                MS_WAIT: begin
                    cnt_reg <= cnt_reg + 1'b1; // RL3
                    if (sample) begin
                        state_reg <= MS_DONE;
                    end
                end
                MS_DONE: begin
                    state_reg <= MS_IDLE;
                end
                default: begin
                    state_reg <= MS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            own_reg <= 1'b0;
            bc_reg <= 1'b0;
        end else if (sample && !I_CMD_STROBE) begin
            own_reg <= own_next;
            bc_reg <= bc_next;
        end
    end
    assign O_MATCH_VALID = state_reg == MS_DONE;
    assign O_OWN_MATCH = own_reg;
    assign O_BCAST_MATCH = bc_reg;

    // ------------------------------------------------------------------
    // busy lookup
    // ------------------------------------------------------------------
    rab_cmd_if cmd_bus ();
    assign cmd_bus.valid = sample && !I_CMD_STROBE;
    assign cmd_bus.bcast = bc_next;
    assign cmd_bus.tr = cmd_tr_reg;
    assign cmd_bus.subaddr = cmd_sa_reg;
    assign cmd_bus.enable = lookup_en; // RL17
    assign O_BUSY = cmd_bus.busy;

    rab_busy_lookup u_busy (
        .i_clk(I_CLK),
        .i_resetn(I_RESETN),
        .i_table(table_flat),
        .cmd(cmd_bus)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence cmd_taken_s;
        I_CMD_STROBE ##1 !I_CMD_STROBE [* 8];
    endsequence
    // quiet cycles since the last strobe; saturates so a long idle never
    // wraps back onto the sample count
    logic [7:0] quiet_reg;
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            quiet_reg <= 8'hFF;
        end else if (I_CMD_STROBE) begin
            quiet_reg <= 8'h00;
        end else if (quiet_reg != 8'hFF) begin
            quiet_reg <= quiet_reg + 8'h01;
        end
    end
    match_needs_parity_a: assert property (@(posedge I_CLK)
        disable iff (!I_RESETN)
        O_MATCH_VALID && O_OWN_MATCH |-> ^$past(held)) // RL1
        else $error("own match without odd parity");
    bcast_off_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        sample && !I_CMD_STROBE && cfg5_bcast_off_reg |=> !bc_reg) // RL2
        else $error("broadcast accepted while disabled");
    sample_time_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        O_MATCH_VALID == (quiet_reg == 8'(SAMPLE_DELAY_CYC))) // RL3
        else $error("match not sampled at 2 us");
    no_early_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        cmd_taken_s |-> !O_MATCH_VALID) // RL3
        else $error("match reported too early");
    hardwired_track_a: assert property (@(posedge I_CLK)
        disable iff (!I_RESETN)
        !I_ADDR_LATCH_SELECT |-> O_HELD_ADDR == strap) // RL7 RL19
        else $error("hardwired address not tracking straps");
    edge_load_a: assert property (@(posedge I_CLK)
        disable iff (!I_RESETN || !I_MASTER_CLEAR_N)
        sel_rise |=> latch_reg == $past(strap)) // RL8
        else $error("latch not loaded on select edge");
    sw_load_a: assert property (@(posedge I_CLK)
        disable iff (!I_RESETN || !I_MASTER_CLEAR_N)
        cfg5_write && enh && sw_capture_en
        |=> latch_reg == $past(strap)) // RL9
        else $error("latch not loaded by cfg5 write");
    latch_hold_a: assert property (@(posedge I_CLK)
        disable iff (!I_RESETN || !I_MASTER_CLEAR_N)
        !sel_rise && !(cfg5_write && enh && sw_capture_en)
        |=> $stable(latch_reg)) // RL12
        else $error("latch changed without load");
endmodule : rab_addr_select

// ---- dv/rab_strap_model.sv ----
// partner model: address strap jumpers and latch-select wiring
`timescale 1ns/1ps
module rab_strap_model
    import rab_pkg::*;
(
    // wanted setting
    input wire logic [4:0] i_addr,
    input wire logic i_bad_par,
    input wire logic i_latched,
    // strap pins
    output logic [4:0] o_term_addr_in,
    output logic o_term_addr_parity_in,
    output logic o_addr_latch_select
);
    // jumpers sit on the data lines too, so a host write sees the same
    // address bits that the straps present
    assign o_term_addr_in = i_addr;
    // odd ones count over address plus parity; bad parity only on request
    assign o_term_addr_parity_in = ~(^i_addr) ^ i_bad_par;
    assign o_addr_latch_select = i_latched;
endmodule : rab_strap_model

// ---- dv/rab_addr_select_tb.sv ----
// testbench: registers, straps, address match and busy lookup
`timescale 1ns/1ps
module rab_addr_select_tb
    import rab_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n, cyc, stb, we, ack, bad_par, latched, mclr_n;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, q;
    logic [4:0] s_addr, t_addr, c_addr, c_sa;
    logic t_par, lsel, strobe, c_tr, mv, own, bc, busy;
    logic [5:0] held;
    int fails, n_tests, cycles;
    always #10 clk = ~clk;
    rab_strap_model i_rab_strap_model (.i_addr(s_addr), .i_bad_par(bad_par),
        .i_latched(latched), .o_term_addr_in(t_addr),
        .o_term_addr_parity_in(t_par), .o_addr_latch_select(lsel));
    rab_addr_select i_rab_addr_select (.I_CLK(clk), .I_RESETN(rst_n),
        .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
        .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .I_TERM_ADDR_IN(t_addr), .I_TERM_ADDR_PARITY_IN(t_par),
        .I_ADDR_LATCH_SELECT(lsel), .I_MASTER_CLEAR_N(mclr_n),
        .I_CMD_STROBE(strobe), .I_CMD_ADDR(c_addr), .I_CMD_TR(c_tr),
        .I_CMD_SUBADDR(c_sa), .O_MATCH_VALID(mv), .O_OWN_MATCH(own),
        .O_BCAST_MATCH(bc), .O_BUSY(busy), .O_HELD_ADDR(held));
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // classic cycle; one idle edge always precedes the next request
    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask : wb
    task automatic tc(input logic [4:0] a, input logic t, input logic [4:0] s,
                      input logic e_own, e_bc, e_busy);
        int n;
        @(posedge clk);
        strobe <= 1'b1; c_addr <= a; c_tr <= t; c_sa <= s;
        @(posedge clk);
        strobe <= 1'b0;
        n = 0;
        while (mv !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        // sample 2 us after the strobe edge, result one edge later
        chk("match_delay", n, SAMPLE_DELAY_CYC + 1);
        chk("own_bcast_busy", {29'h0, own, bc, busy},
            {29'h0, e_own, e_bc, e_busy});
    endtask : tc
    // ------------------------------------------------------------------
    // timeout: about 2500 cycles of traffic expected
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
        wdat = 32'h0; s_addr = 5'h05; bad_par = 1'b0; latched = 1'b0;
        mclr_n = 1'b1; strobe = 1'b0; c_addr = 5'h00; c_tr = 1'b0;
        c_sa = 5'h00; fails = 0; n_tests = 0; cycles = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("held_hw", {26'h0, held}, {26'h0, 5'h05, ~^5'h05});
        tc(5'h05, 1'b0, 5'h00, 1'b1, 1'b0, 1'b0);
        tc(5'h06, 1'b0, 5'h00, 1'b0, 1'b0, 1'b0);
        bad_par <= 1'b1;
        tc(5'h05, 1'b0, 5'h00, 1'b0, 1'b0, 1'b0);
        tc(BCAST_ADDR, 1'b0, 5'h00, 1'b0, 1'b1, 1'b0);
        bad_par <= 1'b0;
        wb(OFF_CFG5, 1'b1, 32'h80);
        tc(BCAST_ADDR, 1'b0, 5'h00, 1'b0, 1'b0, 1'b0);
        wb(OFF_CFG5, 1'b1, 32'h0);
        wb(OFF_CFG3, 1'b1, 32'h8000);
        wb(OFF_CFG5, 1'b0, 32'h0);
        chk("cfg5_hw", q, {24'h0, 2'b00, 5'h05, ~^5'h05});
        wb(8'h40, 1'b0, 32'h0);
        chk("unmapped", q, 32'h0);
        // each word marks a different bit so a wrong index shows up
        for (int k = 0; k < BUSY_WORDS; k++) begin
            wb(OFF_BUSY_BASE + 8'(4 * k), 1'b1, 32'h1 << (2 * k));
        end
        for (int k = 0; k < BUSY_WORDS; k++) begin
            wb(OFF_BUSY_BASE + 8'(4 * k), 1'b0, 32'h0);
            chk("busy_word", q, 32'h1 << (2 * k));
        end
        tc(5'h05, 1'b0, 5'h00, 1'b1, 1'b0, 1'b0);
        wb(OFF_CFG2, 1'b1, 32'h2000);
        for (int k = 0; k < BUSY_WORDS; k++) begin
            tc(k[2] ? BCAST_ADDR : 5'h05, k[1], {k[0], 4'(2 * k)},
               !k[2], k[2], 1'b1);
            tc(k[2] ? BCAST_ADDR : 5'h05, k[1], {k[0], 4'(2 * k + 1)},
               !k[2], k[2], 1'b0);
        end
        s_addr <= 5'h09;
        repeat (2) @(posedge clk);
        latched <= 1'b1;
        repeat (2) @(posedge clk);
        s_addr <= 5'h03;
        repeat (2) @(posedge clk);
        chk("held_edge", {26'h0, held}, {26'h0, 5'h09, ~^5'h09});
        tc(5'h09, 1'b0, 5'h00, 1'b1, 1'b0, 1'b1);
        wb(OFF_CFG5, 1'b0, 32'h0);
        chk("cfg5_lat", q, {24'h0, 2'b01, 5'h09, ~^5'h09});
        wb(OFF_CFG4, 1'b1, 32'h8);
        wb(OFF_CFG5, 1'b1, 32'h0);
        // capture lands on the edge that takes the write, before ack is seen; one more edge anyway
        @(posedge clk);
        chk("held_sw", {26'h0, held}, {26'h0, 5'h03, ~^5'h03});
        mclr_n <= 1'b0;
        repeat (5) @(posedge clk);
        chk("held_clr", {26'h0, held}, 32'h0);
        mclr_n <= 1'b1;
        end_of_test();
    end
endmodule : rab_addr_select_tb
